// ==== core/ble_ack_time_regs.sv ====
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module ble_ack_time_regs
  import ble_regs_pkg::*;
#(
  parameter int BASE_TICK_CYCLES_P = BASE_TICK_CYCLES, // Cycles per 625 us.
  parameter int US_TICK_CYCLES_P = US_TICK_CYCLES // Cycles per microsecond.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [31:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [31:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic [IRQ_COUNT-1:0] irq_event, // Source event pulses.
  input wire logic ext_wake_req, // External wake-up pin.
  output logic [IRQ_COUNT-1:0] irq_raw_flag, // Raw pending flags.
  output logic [IRQ_COUNT-1:0] irq_masked_flag, // Masked pending flags.
  output logic [31:0] dev_addr_low_part, // Device address, low part.
  output logic [DEV_HIGH_W-1:0] dev_addr_high_part, // Device address, high part.
  output logic address_type_private, // High for a private address.
  output logic [RX_PTR_W-1:0] rx_chain_start, // First receive descriptor.
  output logic external_wake_block, // High blocks external wake-up.
  output logic wake_request // Accepted external wake-up level.
);

  // ==========================================================================
  // Helper functions.

  // Expands byte strobes into a bit mask.
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // Tells whether an address hits one of the registers.
  function automatic logic is_mapped(input logic [31:0] addr);
    logic hit;
    case (addr)
      ADDR_IRQ_ACK, ADDR_BASE_TIME, ADDR_FINE_TIME, ADDR_DEV_LOW,
      ADDR_DEV_HIGH, ADDR_RX_PTR, ADDR_SLEEP_CTRL, ADDR_IRQ_MASK,
      ADDR_IRQ_MASKED, ADDR_IRQ_RAW, ADDR_SAMPLE_TRIG: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : is_mapped

  // ==========================================================================
  // Declarations.
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data, wr_bits, wr_mask;
  logic [3:0] w_strb, next_w_strb;
  logic aw_held, next_aw_held, w_held, next_w_held, next_awready, next_wready;
  logic next_bvalid, do_write, next_arready, next_rvalid, rd_take;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;

  logic [IRQ_COUNT-1:0] irq_mask, next_irq_mask, irq_ack, irq_set;
  logic [31:0] ack_bits, next_dev_addr_low_part;
  logic [BASE_TIME_W-1:0] base_time_snapshot, next_base_time_snapshot;
  logic [DEV_HIGH_W-1:0] next_dev_addr_high_part;
  logic next_address_type_private, next_external_wake_block, time_sample_trigger;
  logic [RX_PTR_W-1:0] next_rx_chain_start;

  logic [BASE_TIME_W-1:0] base_time_value;
  logic [FINE_TIME_W-1:0] microsecond_count;
  logic base_tick;

  logic wake_s1;
  logic wake_s2;
  logic wake_s3;
  logic wake_level;
  logic next_wake_level;
  logic next_wake_request;

  // ==========================================================================
  // Write channel.
  // Address and data are taken in either order; once both are held, the write
  // and its response both take effect on the next edge.
  always_comb begin
    do_write = aw_held && w_held && !bvalid;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (awvalid && awready) begin
        next_aw_addr = awaddr;
        next_aw_held = 1'b1;
      end
      if (wvalid && wready) begin
        next_w_data = wdata;
        next_w_strb = wstrb;
        next_w_held = 1'b1;
      end
      if (bvalid && bready) begin
        next_bvalid = 1'b0;
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // Write channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= RESET_WORD;
      w_data <= RESET_WORD;
      w_strb <= 4'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // ==========================================================================
  // Acknowledge decode.
  // Only bits with a one and an enabled byte lane clear their source.
  always_comb begin
    wr_mask = strb_mask(w_strb);
    wr_bits = w_data & wr_mask;
    ack_bits = (do_write && aw_addr == ADDR_IRQ_ACK) ? wr_bits : RESET_WORD;
    irq_ack[IRQ_RADIO_CTRL] = ack_bits[IRQ_RADIO_CTRL];
    irq_ack[IRQ_FINE_TARGET] = ack_bits[IRQ_FINE_TARGET];
    irq_ack[IRQ_GROSS_TARGET] = ack_bits[IRQ_GROSS_TARGET];
    irq_ack[IRQ_ERROR] = ack_bits[IRQ_ERROR];
    irq_ack[IRQ_CIPHER] = ack_bits[IRQ_CIPHER];
    irq_ack[IRQ_END_EVENT] = ack_bits[IRQ_END_EVENT];
    irq_ack[IRQ_SLEEP_END] = ack_bits[IRQ_SLEEP_END];
    irq_ack[IRQ_PACKET_RX] = ack_bits[IRQ_PACKET_RX];
    irq_ack[IRQ_BASE_TICK] = ack_bits[IRQ_BASE_TICK];
    // The base-time source is also raised by the block's own tick.
    irq_set = irq_event;
    irq_set[IRQ_BASE_TICK] = irq_event[IRQ_BASE_TICK] | base_tick;
  end

  // ==========================================================================
  // Register file.
  // Writable fields merge byte lanes; reserved bits are simply not stored.
  always_comb begin
    next_irq_mask = irq_mask;
    next_base_time_snapshot = base_time_snapshot;
    next_dev_addr_low_part = dev_addr_low_part;
    next_dev_addr_high_part = dev_addr_high_part;
    next_address_type_private = address_type_private;
    next_rx_chain_start = rx_chain_start;
    next_external_wake_block = external_wake_block;
    time_sample_trigger = do_write && aw_addr == ADDR_SAMPLE_TRIG;
    if (do_write) begin
      case (aw_addr)
        ADDR_IRQ_MASK: begin
          next_irq_mask = (irq_mask & ~wr_mask[IRQ_COUNT-1:0])
                          | wr_bits[IRQ_COUNT-1:0];
        end
        ADDR_DEV_LOW: begin
          next_dev_addr_low_part = (dev_addr_low_part & ~wr_mask) | wr_bits;
        end
        ADDR_DEV_HIGH: begin
          if (w_strb[0]) begin
            next_dev_addr_high_part[7:0] = w_data[7:0];
          end
          if (w_strb[1]) begin
            next_dev_addr_high_part[15:8] = w_data[15:8];
          end
          if (w_strb[2]) begin
            next_address_type_private = w_data[ADDR_TYPE_BIT];
          end
        end
        ADDR_RX_PTR: begin
          next_rx_chain_start = (rx_chain_start & ~wr_mask[RX_PTR_W-1:0])
                                | wr_bits[RX_PTR_W-1:0];
        end
        ADDR_SLEEP_CTRL: begin
          if (w_strb[3]) begin
            next_external_wake_block = w_data[EXT_WAKE_BIT];
          end
        end
        default: begin
          next_irq_mask = irq_mask;
        end
      endcase
    end
    if (time_sample_trigger) begin
      next_base_time_snapshot = base_time_value;
    end
  end

  // Register file flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= IRQ_MASK_RESET;
      base_time_snapshot <= '0;
      dev_addr_low_part <= RESET_WORD;
      dev_addr_high_part <= '0;
      address_type_private <= 1'b0;
      rx_chain_start <= '0;
      external_wake_block <= 1'b0;
    end else begin
      irq_mask <= next_irq_mask;
      base_time_snapshot <= next_base_time_snapshot;
      dev_addr_low_part <= next_dev_addr_low_part;
      dev_addr_high_part <= next_dev_addr_high_part;
      address_type_private <= next_address_type_private;
      rx_chain_start <= next_rx_chain_start;
      external_wake_block <= next_external_wake_block;
    end
  end

  // ==========================================================================
  // Read channel.
  // One read at a time: the data are registered on the same edge that takes the address.
  always_comb begin
    rd_word = RESET_WORD;
    case (araddr)
      ADDR_IRQ_ACK: rd_word = RESET_WORD;
      ADDR_BASE_TIME: rd_word[BASE_TIME_W-1:0] = base_time_snapshot;
      ADDR_FINE_TIME: rd_word[FINE_TIME_W-1:0] = microsecond_count;
      ADDR_DEV_LOW: rd_word = dev_addr_low_part;
      ADDR_DEV_HIGH: begin
        rd_word[DEV_HIGH_W-1:0] = dev_addr_high_part;
        rd_word[ADDR_TYPE_BIT] = address_type_private;
      end
      ADDR_RX_PTR: rd_word[RX_PTR_W-1:0] = rx_chain_start;
      ADDR_SLEEP_CTRL: rd_word[EXT_WAKE_BIT] = external_wake_block;
      ADDR_IRQ_MASK: rd_word[IRQ_COUNT-1:0] = irq_mask;
      ADDR_IRQ_MASKED: rd_word[IRQ_COUNT-1:0] = irq_masked_flag;
      ADDR_IRQ_RAW: rd_word[IRQ_COUNT-1:0] = irq_raw_flag;
      default: rd_word = RESET_WORD;
    endcase
    rd_take = arvalid && arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= RESET_WORD;
      rresp <= RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==========================================================================
  // External wake-up.
  // The pin passes three stages; the level moves only when the last two agree.
  always_comb begin
    next_wake_level = (wake_s2 == wake_s3) ? wake_s3 : wake_level;
    next_wake_request = wake_level && !external_wake_block;
  end

  // Wake synchroniser and output registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
      wake_level <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      wake_s1 <= ext_wake_req;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      wake_level <= next_wake_level;
      wake_request <= next_wake_request;
    end
  end

  // ==========================================================================
  // Submodules.

  // Raw and masked flags for all sources.
  irq_flag_bank #(
    .N(IRQ_COUNT)
  ) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_event(irq_set),
    .clear_ack(irq_ack),
    .mask_next(next_irq_mask),
    .raw_flag(irq_raw_flag),
    .masked_flag(irq_masked_flag)
  );

  // Base-time and microsecond counters.
  time_counters #(
    .TICK_CYCLES(BASE_TICK_CYCLES_P),
    .US_CYCLES(US_TICK_CYCLES_P)
  ) u_time (
    .aclk(aclk),
    .aresetn(aresetn),
    .base_time_value(base_time_value),
    .microsecond_count(microsecond_count),
    .base_tick(base_tick)
  );

endmodule : ble_ack_time_regs

// ==== core/ble_regs_pkg.sv ====
// Overview of operation
// - Each source keeps raw and masked flag
// - Ack bit 8 clears radio controller flags
// - Ack bit 7 clears fine target flags
// - Ack bit 6 clears gross target flags
// - Ack bit 5 clears error flags
// - Ack bit 4 clears cipher flags
// - Ack bit 3 clears end-of-event flags
// - Ack bit 2 clears end-of-sleep flags
// - Ack bit 1 clears packet receive flags
// - Ack bit 0 clears base-time flags
// - Base-time snapshot refreshed on sample trigger
// - Fine counter advances every microsecond
// - Address held as low and high parts
// - Upper bit 16 marks private address
// - Receive descriptor pointer holds chain start
// - Bit 31 blocks external wake-up
package ble_regs_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] ADDR_IRQ_ACK = 32'h4000_0018;
  localparam logic [31:0] ADDR_BASE_TIME = 32'h4000_001C;
  localparam logic [31:0] ADDR_FINE_TIME = 32'h4000_0020;
  localparam logic [31:0] ADDR_DEV_LOW = 32'h4000_0024;
  localparam logic [31:0] ADDR_DEV_HIGH = 32'h4000_0028;
  localparam logic [31:0] ADDR_RX_PTR = 32'h4000_002C;
  localparam logic [31:0] ADDR_SLEEP_CTRL = 32'h4000_0030;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_0100;
  localparam logic [31:0] ADDR_IRQ_MASKED = 32'h4000_0104;
  localparam logic [31:0] ADDR_IRQ_RAW = 32'h4000_0108;
  localparam logic [31:0] ADDR_SAMPLE_TRIG = 32'h4000_010C;

  // ==========================================================================
  // Interrupt source positions, shared by acknowledge, mask and status words.
  localparam int IRQ_COUNT = 9;
  localparam int IRQ_BASE_TICK = 0;
  localparam int IRQ_PACKET_RX = 1;
  localparam int IRQ_SLEEP_END = 2;
  localparam int IRQ_END_EVENT = 3;
  localparam int IRQ_CIPHER = 4;
  localparam int IRQ_ERROR = 5;
  localparam int IRQ_GROSS_TARGET = 6;
  localparam int IRQ_FINE_TARGET = 7;
  localparam int IRQ_RADIO_CTRL = 8;

  // ==========================================================================
  // Field widths and positions.
  localparam int BASE_TIME_W = 27;
  localparam int FINE_TIME_W = 10;
  localparam int DEV_HIGH_W = 16;
  localparam int ADDR_TYPE_BIT = 16;
  localparam int RX_PTR_W = 14;
  localparam int EXT_WAKE_BIT = 31;

  // ==========================================================================
  // Values after reset and bus responses.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [8:0] IRQ_MASK_RESET = 9'h1DF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timing: the clock period and the two time bases, in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;
  localparam int BASE_PERIOD_NS = 625000;
  localparam int MICROSECOND_NS = 1000;
  localparam int BASE_TICK_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int US_TICK_CYCLES = MICROSECOND_NS / CLK_PERIOD_NS;

endpackage : ble_regs_pkg

// ==== core/irq_flag_bank.sv ====
`timescale 1ns/1ps
module irq_flag_bank
  import ble_regs_pkg::*;
#(
  parameter int N = IRQ_COUNT // Number of interrupt sources.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [N-1:0] set_event, // One-cycle source events.
  input wire logic [N-1:0] clear_ack, // One-cycle acknowledge strobes.
  input wire logic [N-1:0] mask_next, // Mask value as of the next edge.
  output logic [N-1:0] raw_flag, // Sticky raw pending flags.
  output logic [N-1:0] masked_flag // Raw flags gated by the mask.
);

  logic [N-1:0] next_raw_flag;
  logic [N-1:0] next_masked_flag;

  // ==========================================================================
  // Flag update.
  // A new event beats an acknowledge in the same cycle, so no event is lost.
  always_comb begin
    next_raw_flag = (raw_flag & ~clear_ack) | set_event;
    next_masked_flag = next_raw_flag & mask_next;
  end

  // Flag registers, cleared by reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_flag <= '0;
      masked_flag <= '0;
    end else begin
      raw_flag <= next_raw_flag;
      masked_flag <= next_masked_flag;
    end
  end

endmodule : irq_flag_bank

// ==== core/time_counters.sv ====
`timescale 1ns/1ps
module time_counters
  import ble_regs_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_TICK_CYCLES, // Clock cycles per base tick.
  parameter int US_CYCLES = US_TICK_CYCLES // Clock cycles per microsecond.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  output logic [BASE_TIME_W-1:0] base_time_value, // Running base-time count.
  output logic [FINE_TIME_W-1:0] microsecond_count, // Microseconds in this slot.
  output logic base_tick // One-cycle pulse per base period.
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int UW = $clog2(US_CYCLES);

  logic [TW-1:0] tick_div;
  logic [TW-1:0] next_tick_div;
  logic [UW-1:0] us_div;
  logic [UW-1:0] next_us_div;
  logic us_edge;
  logic next_base_tick;
  logic [BASE_TIME_W-1:0] next_base_time_value;
  logic [FINE_TIME_W-1:0] next_microsecond_count;

  // ==========================================================================
  // Dividers and counters.
  // The fine count restarts with each base tick so it measures within a slot.
  always_comb begin
    next_base_tick = (tick_div == TW'(TICK_CYCLES - 1));
    next_tick_div = next_base_tick ? '0 : tick_div + 1'b1;
    us_edge = (us_div == UW'(US_CYCLES - 1));
    next_us_div = (us_edge || next_base_tick) ? '0 : us_div + 1'b1;
    if (next_base_tick) begin
      next_microsecond_count = '0;
    end else if (us_edge) begin
      next_microsecond_count = microsecond_count + 1'b1;
    end else begin
      next_microsecond_count = microsecond_count;
    end
    next_base_time_value = next_base_tick ? base_time_value + 1'b1 : base_time_value;
  end

  // Counter registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_div <= '0;
      us_div <= '0;
      base_tick <= 1'b0;
      base_time_value <= '0;
      microsecond_count <= '0;
    end else begin
      tick_div <= next_tick_div;
      us_div <= next_us_div;
      base_tick <= next_base_tick;
      base_time_value <= next_base_time_value;
      microsecond_count <= next_microsecond_count;
    end
  end

endmodule : time_counters

// ==== tb/ble_regs_monitor.sv ====
`timescale 1ns/1ps
// ==========
// Port checks on the register slice.
module ble_regs_monitor
  import ble_regs_pkg::*;
(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic awvalid, // Bus.
  input wire logic awready, // Bus.
  input wire logic wvalid, // Bus.
  input wire logic wready, // Bus.
  input wire logic [1:0] bresp, // Bus.
  input wire logic bvalid, // Bus.
  input wire logic bready, // Bus.
  input wire logic [31:0] rdata, // Bus.
  input wire logic rvalid, // Bus.
  input wire logic rready, // Bus.
  input wire logic [IRQ_COUNT-1:0] irq_event, // Events.
  input wire logic [IRQ_COUNT-1:0] irq_raw_flag, // Raw flags.
  input wire logic [IRQ_COUNT-1:0] irq_masked_flag, // Masked flags.
  input wire logic [31:0] dev_addr_low_part, // Address.
  input wire logic external_wake_block, // Block bit.
  input wire logic wake_request // Wake level.
);
  // One clock domain for every check.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  flag_subset_a: assert property ((irq_masked_flag & ~irq_raw_flag) == '0)
    else $error("Masked flag without raw flag.");
  event_set_a: assert property (
    irq_event != '0 |=> (irq_raw_flag & $past(irq_event)) == $past(irq_event))
    else $error("Event did not set its flag.");
  ack_clear_a: assert property (
    ($past(irq_raw_flag) & ~irq_raw_flag) != '0 |-> $rose(bvalid))
    else $error("Flag cleared without a write.");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped early.");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped early.");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("Write response late.");
  addr_write_a: assert property (!$stable(dev_addr_low_part) |-> $rose(bvalid))
    else $error("Address changed without a write.");
  wake_gate_a: assert property (wake_request |-> !$past(external_wake_block))
    else $error("Wake passed while blocked.");
endmodule : ble_regs_monitor

// ==== tb/test_ble_core_ack_time_addr_regs.sv ====
`timescale 1ns/1ps
// ==========
// Self-checking bench for the register slice.
module test_ble_core_ack_time_addr_regs
  import ble_regs_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext_wake_req, wake_request;
  logic address_type_private, external_wake_block;
  logic [31:0] awaddr, wdata, araddr, rdata, dev_addr_low_part, rd, v1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [IRQ_COUNT-1:0] irq_event, irq_raw_flag, irq_masked_flag, raw_exp;
  logic [DEV_HIGH_W-1:0] dev_addr_high_part;
  logic [RX_PTR_W-1:0] rx_chain_start;
  int bad_count, cmp_count, cyc;
  logic [31:0] tab_addr [6] = '{ADDR_IRQ_ACK, ADDR_BASE_TIME, ADDR_DEV_LOW,
    ADDR_DEV_HIGH, ADDR_RX_PTR, ADDR_SLEEP_CTRL};
  logic [31:0] tab_exp [6] = '{32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF,
    32'h0001_FFFF, 32'h0000_3FFF, 32'h8000_0000};

  // Design with shortened time bases.
  ble_ack_time_regs #(.BASE_TICK_CYCLES_P(4000), .US_TICK_CYCLES_P(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq_event(irq_event),
    .ext_wake_req(ext_wake_req), .irq_raw_flag(irq_raw_flag),
    .irq_masked_flag(irq_masked_flag), .dev_addr_low_part(dev_addr_low_part),
    .dev_addr_high_part(dev_addr_high_part), .address_type_private(address_type_private),
    .rx_chain_start(rx_chain_start), .external_wake_block(external_wake_block),
    .wake_request(wake_request)
  );

  // Clock of 20 ns.
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // Cycle count that cuts a hang short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  // ==========
  // Tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Write: both channels offered together, each released once taken; the
  // response is stalled one cycle before it is accepted.
  task automatic axw(input logic [31:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hF);
    logic aw_done = 1'h0;
    logic w_done = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      aw_done = aw_done | awready;
      w_done = w_done | wready;
      if (aw_done) awvalid <= 1'h0;
      if (w_done) wvalid <= 1'h0;
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h1;
    do @(posedge aclk); while (!bvalid);
    chk(bresp, er);
    bready <= 1'h0;
  endtask : axw

  // Read, masked compare; the data is held by a one-cycle stall.
  task automatic axr(input logic [31:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    chk(rdata & m, exp);
    chk(rresp, er);
    rready <= 1'h0;
  endtask : axr

  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // ==========
  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_wake_req} = '0;
    {awaddr, wdata, araddr, wstrb, irq_event} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (tab_addr[i]) axr(tab_addr[i], 32'h0000_0000);
    foreach (tab_addr[i]) begin
      axw(tab_addr[i], 32'hFFFF_FFFF);
      axr(tab_addr[i], tab_exp[i]);
    end
    chk({address_type_private, dev_addr_high_part}, 32'h0001_FFFF);
    chk({external_wake_block, rx_chain_start}, 32'h0000_7FFF);
    axw(ADDR_DEV_LOW, 32'h0000_0000, RESP_OKAY, 4'h1);
    axr(ADDR_DEV_LOW, 32'hFFFF_FF00);
    chk(dev_addr_low_part, 32'hFFFF_FF00);
    axw(32'h4000_0200, 32'hFFFF_FFFF, RESP_SLVERR);
    axr(32'h4000_0200, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int i = 0; i < IRQ_COUNT; i++) begin
      irq_event <= 9'h1FF;
      @(posedge aclk);
      irq_event <= 9'h000;
      axw(ADDR_IRQ_ACK, 32'h0000_0000);
      raw_exp = 9'h1FF ^ (9'h001 << i);
      axw(ADDR_IRQ_ACK, 32'(9'h001 << i));
      chk(irq_raw_flag, raw_exp);
      chk(irq_masked_flag, raw_exp & IRQ_MASK_RESET);
    end
    axr(ADDR_FINE_TIME, 32'h0000_0000, 32'hFFFF_FC00);
    v1 = rd;
    repeat (40) @(posedge aclk);
    axr(ADDR_FINE_TIME, 32'h0000_0000, 32'hFFFF_FC00);
    chk(32'(rd - v1 inside {[10:11]}), 32'h0000_0001);
    while (cyc < 4300) @(posedge aclk);
    axr(ADDR_BASE_TIME, 32'h0000_0000);
    axw(ADDR_SAMPLE_TRIG, 32'h0000_0001);
    axr(ADDR_BASE_TIME, 32'h0000_0001);
    while (cyc < 8300) @(posedge aclk);
    axr(ADDR_BASE_TIME, 32'h0000_0001);
    axw(ADDR_SAMPLE_TRIG, 32'h0000_0001);
    axr(ADDR_BASE_TIME, 32'h0000_0002);
    ext_wake_req <= 1'h1;
    repeat (10) @(posedge aclk);
    chk(wake_request, 32'h0000_0000);
    axw(ADDR_SLEEP_CTRL, 32'h0000_0000);
    repeat (10) @(posedge aclk);
    chk(wake_request, 32'h0000_0001);
    tally_and_finish();
  end
endmodule : test_ble_core_ack_time_addr_regs

bind ble_ack_time_regs ble_regs_monitor mon (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .irq_event(irq_event), .irq_raw_flag(irq_raw_flag),
  .irq_masked_flag(irq_masked_flag), .dev_addr_low_part(dev_addr_low_part),
  .external_wake_block(external_wake_block), .wake_request(wake_request)
);
